// *** pel_consts.svh ***
`ifndef PEL_CONSTS_SVH
`define PEL_CONSTS_SVH
// register indexes on the management port
`define PEL_IDX_GCAP 5'h0f
`define PEL_IDX_LCTL 5'h10
`define PEL_IDX_MODE 5'h11
`define PEL_IDX_SMOD 5'h12
// values, reset values and writable masks
`define PEL_GCAP_VALUE 16'h3000
`define PEL_LCTL_RST 16'h0020
`define PEL_LCTL_WMASK 16'h033d
`define PEL_MODE_RST 16'h0040
`define PEL_MODE_WMASK 16'hf0e0
`define PEL_SMOD_WMASK 16'h001f
// link control fields
`define PEL_LC_SOPT_HI 9
`define PEL_LC_SOPT_LO 8
`define PEL_LC_LBT_HI 5
`define PEL_LC_LBT_LO 4
`define PEL_LC_LBE 3
`define PEL_LC_POD 2
`define PEL_LC_LOGIC_RESET_TRIGGER 0
// mode control fields
`define PEL_MD_EDS 15
`define PEL_MD_FAST 14
`define PEL_MD_EDPD 13
`define PEL_MD_NLP 12
`define PEL_MD_SOE 7
`define PEL_MD_NPE 6
`define PEL_MD_MDIXD 5
// speed optimizer attempt counts per code
`define PEL_SOPT_ATT0 3'h7
`define PEL_SOPT_ATT1 3'h5
`define PEL_SOPT_ATT2 3'h4
`define PEL_SOPT_ATT3 3'h3
// management frame
`define PEL_PRE_LEN 6'h20
`define PEL_OP_RD 2'h2
`define PEL_OP_WR 2'h1
`define PEL_ADR_LAST 6'h09
`define PEL_DATA_LAST 6'h0f
`define PEL_DATA_END 6'h10
`endif

// *** pel_pkg.sv ***
package pel_pkg;
  typedef logic [4:0] pel_addr_t;
  typedef logic [15:0] pel_word_t;
  typedef enum logic [2:0] {
    S_PRE, S_ST, S_OP, S_ADR, S_TA, S_RDATA, S_WDATA
  } pel_smi_state_t;
endpackage : pel_pkg

// *** pel_regbus_if.sv ***
`timescale 1ns/1ps
interface pel_regbus_if;
  import pel_pkg::*;
  logic mdc_s;
  logic mdio_s;
  logic mdio_o;
  logic mdio_oe;
  pel_addr_t addr;
  pel_addr_t phy_addr;
  logic wr_stb;
  pel_word_t wdata;
  pel_word_t rdata;
  modport smi (input mdc_s, input mdio_s, input rdata, input phy_addr,
               output mdio_o, output mdio_oe, output addr, output wr_stb, output wdata);
  modport regs (output mdc_s, output mdio_s, output rdata, output phy_addr,
                input mdio_o, input mdio_oe, input addr, input wr_stb, input wdata);
endinterface : pel_regbus_if

// *** pel_smi_slave.sv ***
`timescale 1ns/1ps
`include "pel_consts.svh"
module pel_smi_slave (
  input wire logic core_clk,
  input wire logic reset,
  pel_regbus_if.smi bus
);
  import pel_pkg::*;
  pel_smi_state_t state_r, state_nxt;
  logic [5:0] cnt_r, cnt_nxt;
  logic [15:0] sh_r, sh_nxt;
  logic [1:0] op_r, op_nxt;
  pel_addr_t reg_r, reg_nxt;
  logic mdc_d_r;
  logic o_r, o_nxt, oe_r, oe_nxt, wr_r, wr_nxt;
  pel_word_t wdata_r, wdata_nxt;
  logic rise;
  logic [9:0] adr_word;

  // sampling on the rising mdc edge as seen in the core domain
  assign rise = bus.mdc_s & ~mdc_d_r;
  assign adr_word = {sh_r[8:0], bus.mdio_s};

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    op_nxt = op_r;
    reg_nxt = reg_r;
    o_nxt = o_r;
    oe_nxt = oe_r;
    wr_nxt = 1'b0;
    wdata_nxt = wdata_r;
    if (rise) begin
      unique case (state_r)
        S_PRE: begin
          if (bus.mdio_s) begin
            cnt_nxt = (cnt_r == `PEL_PRE_LEN) ? cnt_r : 6'(cnt_r + 6'h01);
          end else if (cnt_r == `PEL_PRE_LEN) begin
            state_nxt = S_ST;
            cnt_nxt = 6'h00;
          end else begin
            cnt_nxt = 6'h00;
          end
        end
        S_ST: begin
          state_nxt = bus.mdio_s ? S_OP : S_PRE;
          cnt_nxt = 6'h00;
        end
        S_OP: begin
          op_nxt = {op_r[0], bus.mdio_s};
          cnt_nxt = 6'(cnt_r + 6'h01);
          if (cnt_r == 6'h01) begin
            state_nxt = S_ADR;
            cnt_nxt = 6'h00;
          end
        end
        S_ADR: begin
          sh_nxt = {sh_r[14:0], bus.mdio_s};
          cnt_nxt = 6'(cnt_r + 6'h01);
          if (cnt_r == `PEL_ADR_LAST) begin
            cnt_nxt = 6'h00;
            reg_nxt = adr_word[4:0];
            // foreign address or bad opcode: drop the frame, stay off the line
            if (adr_word[9:5] == bus.phy_addr &&
                (op_r == `PEL_OP_RD || op_r == `PEL_OP_WR)) begin
              state_nxt = S_TA;
            end else begin
              state_nxt = S_PRE;
            end
          end
        end
        S_TA: begin
          if (op_r == `PEL_OP_RD) begin
            oe_nxt = 1'b1;
            o_nxt = 1'b0;
            sh_nxt = bus.rdata;
            state_nxt = S_RDATA;
            cnt_nxt = 6'h00;
          end else begin
            cnt_nxt = 6'(cnt_r + 6'h01);
            if (cnt_r == 6'h01) begin
              state_nxt = S_WDATA;
              cnt_nxt = 6'h00;
            end
          end
        end
        S_RDATA: begin
          if (cnt_r == `PEL_DATA_END) begin
            oe_nxt = 1'b0;
            o_nxt = 1'b0;
            state_nxt = S_PRE;
            cnt_nxt = 6'h00;
          end else begin
            o_nxt = sh_r[15];
            sh_nxt = {sh_r[14:0], 1'b0};
            cnt_nxt = 6'(cnt_r + 6'h01);
          end
        end
        S_WDATA: begin
          sh_nxt = {sh_r[14:0], bus.mdio_s};
          cnt_nxt = 6'(cnt_r + 6'h01);
          if (cnt_r == `PEL_DATA_LAST) begin
            wr_nxt = 1'b1;
            wdata_nxt = {sh_r[14:0], bus.mdio_s};
            state_nxt = S_PRE;
            cnt_nxt = 6'h00;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_r <= S_PRE;
      cnt_r <= 6'h00;
      sh_r <= 16'h0000;
      op_r <= 2'h0;
      reg_r <= 5'h00;
      mdc_d_r <= 1'b0;
      o_r <= 1'b0;
      oe_r <= 1'b0;
      wr_r <= 1'b0;
      wdata_r <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      op_r <= op_nxt;
      reg_r <= reg_nxt;
      mdc_d_r <= bus.mdc_s;
      o_r <= o_nxt;
      oe_r <= oe_nxt;
      wr_r <= wr_nxt;
      wdata_r <= wdata_nxt;
    end
  end

  assign bus.mdio_o = o_r;
  assign bus.mdio_oe = oe_r;
  assign bus.addr = reg_r;
  assign bus.wr_stb = wr_r;
  assign bus.wdata = wdata_r;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  a_foreign_drop: assert property (rise && state_r == S_ADR && cnt_r == `PEL_ADR_LAST &&
      adr_word[9:5] != bus.phy_addr |=> state_r == S_PRE && !oe_r)
    else $error("frame for another address was not dropped");
  a_read_turn: assert property (rise && state_r == S_TA && op_r == `PEL_OP_RD
      |=> oe_r && !o_r)
    else $error("turnaround zero not driven on read");
  c_read_done: cover property (state_r == S_RDATA && rise && cnt_r == `PEL_DATA_END);
endmodule : pel_smi_slave

// *** pel_regs_top.sv ***
`timescale 1ns/1ps
`include "pel_consts.svh"
// Contract
// - capability bits 15 and 14 read zero, no 1000BASE-X support.
// - capability bits 13 and 12 read one, 1000BASE-T full and half.
// - link control 9:8 picks failed attempts before downshift: 7, 5, 4, 3.
// - mode bit 7 enables the speed optimizer, reset zero.
// - link control 5:4 picks idle error threshold, reset code 10.
// - link fails on threshold only while link control bit 3 is set.
// - link control bit 2 disables power optimization, reset zero.
// - writing one to link control bit 0 pulses a logic reset.
// - link control bit 0 is never cleared by hardware.
// - mode bit 15 selects short energy detect, reset zero.
// - mode bit 14 puts 10BASE-T in fast test mode, reset zero.
// - mode bit 13 enables energy detect power-down, reset zero.
// - mode bit 12 keeps link pulses during power-down, reset zero.
// - mode bit 6 allows next pages, reset one.
// - mode bit 5 disables automatic crossover, reset zero.
// - frames are accepted only for the five-bit address held at bits 4:0.
module pel_regs_top (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic mdc,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe,
  input wire pel_pkg::pel_addr_t addr_strap,
  input wire logic an_attempt_failed,
  input wire logic [3:0] idle_err_over,
  output logic logic_reset_pulse,
  output logic link_fail,
  output logic speed_downshift,
  output logic power_opt_disable,
  output logic short_energy_detect_select,
  output logic ten_meg_test_mode,
  output logic energy_detect_powerdown_enable,
  output logic ed_powerdown_nlp_enable,
  output logic speed_opt_enable,
  output logic next_page_enable,
  output logic auto_mdix_disable,
  output pel_pkg::pel_addr_t management_port_address
);
  import pel_pkg::*;

  pel_regbus_if bus ();

  logic mdc_s1_r, mdc_s2_r, mdio_s1_r, mdio_s2_r;
  pel_addr_t strap_s1_r, strap_s2_r;
  pel_word_t lctl_r, lctl_nxt, mode_r, mode_nxt;
  pel_addr_t addr_r, addr_nxt;
  logic loaded_r, loaded_nxt;
  logic logic_reset_trigger_r, logic_reset_trigger_nxt;
  logic [2:0] sopt_cnt_r, sopt_cnt_nxt;
  logic down_r, down_nxt, fail_r, fail_nxt;

  function automatic logic [2:0] attempt_limit(input logic [1:0] sel);
    logic [2:0] lim;
    lim = `PEL_SOPT_ATT0;
    unique case (sel)
      2'h0: lim = `PEL_SOPT_ATT0;
      2'h1: lim = `PEL_SOPT_ATT1;
      2'h2: lim = `PEL_SOPT_ATT2;
      2'h3: lim = `PEL_SOPT_ATT3;
    endcase
    return lim;
  endfunction : attempt_limit

  function automatic pel_word_t read_word(input pel_addr_t a, input pel_word_t lc,
                                          input pel_word_t md, input pel_addr_t pa);
    pel_word_t w;
    w = 16'h0000;
    unique case (a)
      `PEL_IDX_GCAP: w = `PEL_GCAP_VALUE;
      `PEL_IDX_LCTL: w = lc & `PEL_LCTL_WMASK;
      `PEL_IDX_MODE: w = md & `PEL_MODE_WMASK;
      `PEL_IDX_SMOD: w = {11'h000, pa};
      default: w = 16'h0000;
    endcase
    return w;
  endfunction : read_word

  // pins are asynchronous to core_clk; first stage feeds only the second
  always_ff @(posedge core_clk) begin
    mdc_s1_r <= mdc;
    mdc_s2_r <= mdc_s1_r;
    mdio_s1_r <= mdio_i;
    mdio_s2_r <= mdio_s1_r;
    strap_s1_r <= addr_strap;
    strap_s2_r <= strap_s1_r;
  end

  assign bus.mdc_s = mdc_s2_r;
  assign bus.mdio_s = mdio_s2_r;
  assign bus.phy_addr = addr_r;
  assign bus.rdata = read_word(bus.addr, lctl_r, mode_r, addr_r);

  pel_smi_slave u_smi (
    .core_clk(core_clk),
    .reset(reset),
    .bus(bus.smi)
  );

  always_comb begin
    lctl_nxt = lctl_r;
    mode_nxt = mode_r;
    addr_nxt = addr_r;
    loaded_nxt = 1'b1;
    logic_reset_trigger_nxt = 1'b0;
    // strap caught once, first cycle after release
    if (!loaded_r) begin
      addr_nxt = strap_s2_r;
    end
    if (bus.wr_stb) begin
      unique case (bus.addr)
        `PEL_IDX_LCTL: begin
          // bit 0 keeps what was written; nothing here ever clears it
          lctl_nxt = bus.wdata & `PEL_LCTL_WMASK;
          logic_reset_trigger_nxt = bus.wdata[`PEL_LC_LOGIC_RESET_TRIGGER];
        end
        `PEL_IDX_MODE: mode_nxt = bus.wdata & `PEL_MODE_WMASK;
        `PEL_IDX_SMOD: addr_nxt = bus.wdata[4:0];
        default: lctl_nxt = lctl_r;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      lctl_r <= `PEL_LCTL_RST;
      mode_r <= `PEL_MODE_RST;
      addr_r <= 5'h00;
      loaded_r <= 1'b0;
      logic_reset_trigger_r <= 1'b0;
    end else begin
      lctl_r <= lctl_nxt;
      mode_r <= mode_nxt;
      addr_r <= addr_nxt;
      loaded_r <= loaded_nxt;
      logic_reset_trigger_r <= logic_reset_trigger_nxt;
    end
  end

  // speed optimizer and link break; logic reset clears these, not the registers
  always_comb begin
    sopt_cnt_nxt = sopt_cnt_r;
    down_nxt = 1'b0;
    fail_nxt = lctl_r[`PEL_LC_LBE] & idle_err_over[lctl_r[`PEL_LC_LBT_HI:`PEL_LC_LBT_LO]];
    if (!mode_r[`PEL_MD_SOE]) begin
      sopt_cnt_nxt = 3'h0;
    end else if (an_attempt_failed) begin
      if (3'(sopt_cnt_r + 3'h1) >= attempt_limit(lctl_r[`PEL_LC_SOPT_HI:`PEL_LC_SOPT_LO])) begin
        sopt_cnt_nxt = 3'h0;
        down_nxt = 1'b1;
      end else begin
        sopt_cnt_nxt = 3'(sopt_cnt_r + 3'h1);
      end
    end
    if (logic_reset_trigger_r) begin
      sopt_cnt_nxt = 3'h0;
      down_nxt = 1'b0;
      fail_nxt = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      sopt_cnt_r <= 3'h0;
      down_r <= 1'b0;
      fail_r <= 1'b0;
    end else begin
      sopt_cnt_r <= sopt_cnt_nxt;
      down_r <= down_nxt;
      fail_r <= fail_nxt;
    end
  end

  assign mdio_o = bus.mdio_o;
  assign mdio_oe = bus.mdio_oe;
  assign logic_reset_pulse = logic_reset_trigger_r;
  assign link_fail = fail_r;
  assign speed_downshift = down_r;
  assign power_opt_disable = lctl_r[`PEL_LC_POD];
  assign short_energy_detect_select = mode_r[`PEL_MD_EDS];
  assign ten_meg_test_mode = mode_r[`PEL_MD_FAST];
  assign energy_detect_powerdown_enable = mode_r[`PEL_MD_EDPD];
  assign ed_powerdown_nlp_enable = mode_r[`PEL_MD_NLP];
  assign speed_opt_enable = mode_r[`PEL_MD_SOE];
  assign next_page_enable = mode_r[`PEL_MD_NPE];
  assign auto_mdix_disable = mode_r[`PEL_MD_MDIXD];
  assign management_port_address = addr_r;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  a_gcap_x_zero: assert property (bus.addr == `PEL_IDX_GCAP |-> bus.rdata[15:14] == 2'h0)
    else $error("1000BASE-X capability reads nonzero");
  a_gcap_t_set: assert property (bus.addr == `PEL_IDX_GCAP |-> bus.rdata[13:12] == 2'h3)
    else $error("1000BASE-T capability not reported");
  a_reserved_zero: assert property ((bus.addr == `PEL_IDX_GCAP |-> bus.rdata[11:0] == 12'h000)
      and (bus.addr == `PEL_IDX_LCTL |-> (bus.rdata & ~`PEL_LCTL_WMASK) == 16'h0000)
      and (bus.addr == `PEL_IDX_MODE |-> (bus.rdata & ~`PEL_MODE_WMASK) == 16'h0000))
    else $error("reserved bits read nonzero");
  a_sopt_limit: assert property (mode_r[`PEL_MD_SOE] && an_attempt_failed && !logic_reset_trigger_r &&
      3'(sopt_cnt_r + 3'h1) == attempt_limit(lctl_r[9:8]) |=> speed_downshift && sopt_cnt_r == 3'h0)
    else $error("downshift not issued at attempt limit");
  a_sopt_off: assert property (!mode_r[`PEL_MD_SOE] |=> sopt_cnt_r == 3'h0 && !speed_downshift)
    else $error("speed optimizer active while disabled");
  a_break_select: assert property (lctl_r[`PEL_LC_LBE] && !logic_reset_trigger_r &&
      idle_err_over[lctl_r[5:4]] |=> link_fail)
    else $error("selected threshold did not fail link");
  a_break_gated: assert property (!lctl_r[`PEL_LC_LBE] |=> !link_fail)
    else $error("link failed while link break disabled");
  a_power_opt: assert property (bus.wr_stb && bus.addr == `PEL_IDX_LCTL
      |=> power_opt_disable == $past(bus.wdata[2]))
    else $error("power optimization bit not taken");
  a_logic_reset_trigger_pulse: assert property (bus.wr_stb && bus.addr == `PEL_IDX_LCTL && bus.wdata[0]
      |=> logic_reset_pulse ##1 (!link_fail && !speed_downshift && sopt_cnt_r == 3'h0))
    else $error("logic reset did not clear internal state");
  a_logic_reset_trigger_sticky: assert property (lctl_r[0] && !(bus.wr_stb && bus.addr == `PEL_IDX_LCTL)
      |=> lctl_r[0])
    else $error("logic reset bit cleared by hardware");
  a_mode_write: assert property (bus.wr_stb && bus.addr == `PEL_IDX_MODE |=>
      {short_energy_detect_select, ten_meg_test_mode, energy_detect_powerdown_enable,
       ed_powerdown_nlp_enable, next_page_enable, auto_mdix_disable} ==
      {$past(bus.wdata[15:12]), $past(bus.wdata[6:5])})
    else $error("mode control bits not taken");
  a_reset_values: assert property ($fell(reset) |-> next_page_enable && !auto_mdix_disable &&
      lctl_r == `PEL_LCTL_RST && !speed_opt_enable)
    else $error("wrong values after reset");
  c_lctl_write: cover property (bus.wr_stb && bus.addr == `PEL_IDX_LCTL);
  c_downshift: cover property (speed_downshift);
  c_link_fail: cover property (link_fail);
  c_logic_reset: cover property (logic_reset_pulse ##1 !logic_reset_pulse);
endmodule : pel_regs_top

// *** pel_sta_model.sv ***
`timescale 1ns/1ps
module pel_sta_model (
  input wire logic core_clk,
  input wire logic mdio_wire,
  output logic mdc,
  output logic mdio_drv,
  output logic mdio_drv_en
);
  import pel_pkg::*;
  // 16 core cycles per mdc period, the slowest sampler the device allows
  localparam int HALF = 8;

  initial begin
    mdc = 1'b0;
    mdio_drv = 1'b1;
    mdio_drv_en = 1'b0;
  end

  // one mdc period; wire is sampled just before the rise
  task automatic bit_clk(input logic drv, input logic en, output logic smp);
    mdio_drv = drv;
    mdio_drv_en = en;
    repeat (HALF) @(negedge core_clk);
    smp = mdio_wire;
    mdc = 1'b1;
    repeat (HALF) @(negedge core_clk);
    mdc = 1'b0;
  endtask : bit_clk

  task automatic frame(input logic rd, input pel_addr_t phy, input pel_addr_t idx,
                       input pel_word_t wd, output pel_word_t rdat);
    logic [13:0] hdr;
    logic [17:0] tail;
    logic s;
    hdr = {2'b01, (rd ? 2'b10 : 2'b01), phy, idx};
    tail = {2'b10, wd};
    rdat = 16'h0000;
    @(negedge core_clk);
    repeat (32) bit_clk(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) begin
      bit_clk(hdr[i], 1'b1, s);
    end
    if (rd) begin
      // released line floats high by pull-up; first data bit shows before the third rise
      for (int j = 0; j < 19; j++) begin
        bit_clk(1'b1, 1'b0, s);
        if (j >= 2 && j < 18) begin
          rdat = {rdat[14:0], s};
        end
      end
    end else begin
      for (int i = 17; i >= 0; i--) begin
        bit_clk(tail[i], 1'b1, s);
      end
    end
    mdio_drv_en = 1'b0;
  endtask : frame
endmodule : pel_sta_model

// *** phy_ext_status_link_ctrl_regs_tb.sv ***
`timescale 1ns/1ps
module phy_ext_status_link_ctrl_regs_tb;
  import pel_pkg::*;
  localparam pel_addr_t PHY = 5'h05;
  logic core_clk, reset, mdc, mdio_o, mdio_oe, sta_drv, sta_en, mdio_wire;
  pel_addr_t addr_strap, management_port_address;
  logic an_attempt_failed, logic_reset_pulse, link_fail, speed_downshift;
  logic [3:0] idle_err_over;
  logic power_opt_disable, short_energy_detect_select, ten_meg_test_mode;
  logic energy_detect_powerdown_enable, ed_powerdown_nlp_enable, speed_opt_enable;
  logic next_page_enable, auto_mdix_disable;
  pel_word_t mode_out, r;
  int mismatches, comparisons, logic_reset_trigger_cnt, dshift_cnt, d0;
  int lim[4] = '{7, 5, 4, 3};

  // device wins when driving, otherwise the station, otherwise the pull-up
  assign mdio_wire = mdio_oe ? mdio_o : (sta_en ? sta_drv : 1'b1);
  assign mode_out = {short_energy_detect_select, ten_meg_test_mode,
                     energy_detect_powerdown_enable, ed_powerdown_nlp_enable, 4'h0,
                     speed_opt_enable, next_page_enable, auto_mdix_disable, 5'h00};

  pel_regs_top pel_regs_top_i (
    .core_clk(core_clk),
    .reset(reset),
    .mdc(mdc),
    .mdio_i(mdio_wire),
    .mdio_o(mdio_o),
    .mdio_oe(mdio_oe),
    .addr_strap(addr_strap),
    .an_attempt_failed(an_attempt_failed),
    .idle_err_over(idle_err_over),
    .logic_reset_pulse(logic_reset_pulse),
    .link_fail(link_fail),
    .speed_downshift(speed_downshift),
    .power_opt_disable(power_opt_disable),
    .short_energy_detect_select(short_energy_detect_select),
    .ten_meg_test_mode(ten_meg_test_mode),
    .energy_detect_powerdown_enable(energy_detect_powerdown_enable),
    .ed_powerdown_nlp_enable(ed_powerdown_nlp_enable),
    .speed_opt_enable(speed_opt_enable),
    .next_page_enable(next_page_enable),
    .auto_mdix_disable(auto_mdix_disable),
    .management_port_address(management_port_address)
  );

  pel_sta_model pel_sta_model_i (
    .core_clk(core_clk),
    .mdio_wire(mdio_wire),
    .mdc(mdc),
    .mdio_drv(sta_drv),
    .mdio_drv_en(sta_en)
  );

  always #2 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    if (logic_reset_pulse === 1'b1) logic_reset_trigger_cnt++;
    if (speed_downshift === 1'b1) dshift_cnt++;
  end

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  task automatic check(input pel_word_t got, input pel_word_t exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic rd(input pel_addr_t idx, input pel_word_t exp);
    pel_sta_model_i.frame(1'b1, PHY, idx, 16'h0000, r);
    check(r, exp);
  endtask : rd

  task automatic wr(input pel_addr_t idx, input pel_word_t d);
    pel_sta_model_i.frame(1'b0, PHY, idx, d, r);
    repeat (4) @(negedge core_clk);
  endtask : wr

  task automatic fail_pulses(input int n);
    repeat (n) begin
      an_attempt_failed = 1'b1;
      @(negedge core_clk);
      an_attempt_failed = 1'b0;
      repeat (2) @(negedge core_clk);
    end
  endtask : fail_pulses

  initial begin
    repeat (90000) @(posedge core_clk);
    mismatches++;
    complete_run();
  end

  initial begin
    core_clk = 1'b0;
    reset = 1'b1;
    addr_strap = PHY;
    an_attempt_failed = 1'b0;
    idle_err_over = 4'h0;
    repeat (16) @(posedge core_clk);
    @(negedge core_clk);
    reset = 1'b0;
    repeat (4) @(negedge core_clk);
    check({11'h000, management_port_address}, {11'h000, PHY});
    check(mode_out, 16'h0040);
    rd(5'h0f, 16'h3000);
    rd(5'h10, 16'h0020);
    rd(5'h11, 16'h0040);
    wr(5'h0f, 16'h0000);
    rd(5'h0f, 16'h3000);
    wr(5'h11, 16'hffff);
    rd(5'h11, 16'hf0e0);
    check(mode_out, 16'hf0e0);
    wr(5'h11, 16'h0000);
    rd(5'h11, 16'h0000);
    check(mode_out, 16'h0000);
    wr(5'h10, 16'hffff);
    rd(5'h10, 16'h033d);
    check(16'(logic_reset_trigger_cnt), 16'h0001);
    check({15'h0000, power_opt_disable}, 16'h0001);
    // a repeated trigger while the bit already reads one still fires
    wr(5'h10, 16'h0001);
    rd(5'h10, 16'h0001);
    check(16'(logic_reset_trigger_cnt), 16'h0002);
    check({15'h0000, power_opt_disable}, 16'h0000);
    rd(5'h13, 16'h0000);
    pel_sta_model_i.frame(1'b1, PHY ^ 5'h1f, 5'h0f, 16'h0000, r);
    check(r, 16'hffff);
    pel_sta_model_i.frame(1'b0, PHY ^ 5'h01, 5'h10, 16'h0004, r);
    rd(5'h10, 16'h0001);
    // move the port address, answer on the new one, then move it back
    wr(5'h12, 16'h000a);
    check({11'h000, management_port_address}, 16'h000a);
    pel_sta_model_i.frame(1'b1, 5'h0a, 5'h12, 16'h0000, r);
    check(r, 16'h000a);
    pel_sta_model_i.frame(1'b0, 5'h0a, 5'h12, {11'h000, PHY}, r);
    rd(5'h12, {11'h000, PHY});
    for (int k = 0; k < 4; k++) begin
      wr(5'h10, 16'h0008 | (16'(k) << 4));
      idle_err_over = 4'h1 << k;
      repeat (4) @(negedge core_clk);
      check({15'h0000, link_fail}, 16'h0001);
      idle_err_over = ~(4'h1 << k);
      repeat (4) @(negedge core_clk);
      check({15'h0000, link_fail}, 16'h0000);
    end
    wr(5'h10, 16'h0030);
    idle_err_over = 4'hf;
    repeat (4) @(negedge core_clk);
    check({15'h0000, link_fail}, 16'h0000);
    idle_err_over = 4'h0;
    d0 = dshift_cnt;
    fail_pulses(8);
    check(16'(dshift_cnt - d0), 16'h0000);
    for (int c = 0; c < 4; c++) begin
      wr(5'h11, 16'h0000);
      wr(5'h11, 16'h0080);
      wr(5'h10, 16'(c) << 8);
      d0 = dshift_cnt;
      fail_pulses(lim[c] - 1);
      check(16'(dshift_cnt - d0), 16'h0000);
      fail_pulses(1);
      repeat (3) @(negedge core_clk);
      check(16'(dshift_cnt - d0), 16'h0001);
    end
    complete_run();
  end
endmodule : phy_ext_status_link_ctrl_regs_tb
